//--- inc/digipot_pkg.sv
// constants for the digipot serial write port
// assumes one core clock ref_clk that samples every pin
//------------------------------------------------------------
// Overview of operation
// - 16-bit shift register, sample on sclk fall
// - frame select low enables shifting
// - frame select rise after 16 clocks updates
// - early frame select rise aborts, no change
// - serial output open-drain, host pulls up
// - serial register shifted out for readback, chain
// - open-drain active-high completion flag
// - reset pin rise loads wiper midscale
// - msb first: 2 zero, 4 control, 10 data
// - serial output changes on sclk rise
// - frames are whole multiples of sixteen clocks
//------------------------------------------------------------
package digipot_pkg;
  localparam int FRAME_BITS = 16;
  localparam int DATA_BITS = 10;
  localparam int CMD_MSB = 13;
  localparam int CMD_LSB = 10;
  localparam logic [3:0] CMD_NOP = 4'h0;
  localparam logic [3:0] CMD_WRITE = 4'h1;
  localparam logic [3:0] CMD_READ = 4'h2;
  localparam logic [3:0] CMD_SW_RESET = 4'h3;
  localparam logic [3:0] CMD_CTRL_WRITE = 4'h4;
  localparam logic [3:0] CMD_CTRL_READ = 4'h5;
  localparam logic [DATA_BITS-1:0] WIPER_MIDSCALE = 10'h200;
  localparam logic [3:0] CTRL_RESET = 4'h0;
  localparam int CTRL_WP_BIT = 1;
  localparam logic [3:0] BITCNT_RESET = 4'h0;
  localparam logic [FRAME_BITS-1:0] SHIFT_RESET = 16'h0000;
  // {hw_reset, sdin, sclk, frame_sel_n} idle levels
  localparam logic [3:0] PIN_RESET = 4'h9;
  localparam int REF_CLK_HZ = 25000000;
  localparam int BUSY_NS = 200;
  localparam int BUSY_CYCLES = (BUSY_NS * (REF_CLK_HZ / 1000000) + 999) / 1000;
  localparam logic [3:0] BUSY_LOAD = 4'(BUSY_CYCLES);
  localparam logic [3:0] BUSY_RESET = 4'h0;
endpackage

//--- hw/pin_sync.sv
// two-flop synchroniser for a vector of pins
// assumes inputs asynchronous to ref_clk
`timescale 1ns/10ps
module pin_sync #(
  parameter int W = 4,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] pin_sync_out
);
  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] sync_r;
  logic [W-1:0] sync_nxt;

  always_comb begin
    meta_nxt = pin_in;
    sync_nxt = meta_r;
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      meta_r <= INIT;
      sync_r <= INIT;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign pin_sync_out = sync_r;
endmodule

//--- hw/digipot_serial_write_port.sv
// serial port of a 1024-position digital potentiometer
// assumes host pins asynchronous; sampled by ref_clk via pin_sync
`timescale 1ns/10ps
module digipot_serial_write_port
  import digipot_pkg::*;
(
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic frame_sel_n,
  input wire logic sclk,
  input wire logic sdin,
  input wire logic hw_reset,
  output logic serial_out_o,
  output logic serial_out_oe,
  output logic ready_o,
  output logic ready_oe,
  output logic [DATA_BITS-1:0] wiper_register,
  output logic [3:0] ctrl_bits
);
  //------------------------------------------------------------
  // pin synchronisation
  //------------------------------------------------------------
  logic [3:0] pins_s;
  // flops start at idle pin levels, so no false edge after reset
  pin_sync #(.W(4), .INIT(PIN_RESET)) u_sync (
    .ref_clk(ref_clk),
    .srst(srst),
    .pin_in({hw_reset, sdin, sclk, frame_sel_n}),
    .pin_sync_out(pins_s)
  );
  logic fs_n_s;
  logic sclk_s;
  logic din_s;
  logic rst_s;
  assign fs_n_s = pins_s[0];
  assign sclk_s = pins_s[1];
  assign din_s = pins_s[2];
  assign rst_s = pins_s[3];

  //------------------------------------------------------------
  // edge detection
  //------------------------------------------------------------
  logic fs_n_d_r, fs_n_d_nxt;
  logic sclk_d_r, sclk_d_nxt;
  logic rst_d_r, rst_d_nxt;
  logic sclk_fall, sclk_rise, fs_rise, fs_fall, rst_rise;

  always_comb begin
    fs_n_d_nxt = fs_n_s;
    sclk_d_nxt = sclk_s;
    rst_d_nxt = rst_s;
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      fs_n_d_r <= 1'b1;
      sclk_d_r <= 1'b0;
      rst_d_r <= 1'b1;
    end else begin
      fs_n_d_r <= fs_n_d_nxt;
      sclk_d_r <= sclk_d_nxt;
      rst_d_r <= rst_d_nxt;
    end
  end

  assign sclk_fall = sclk_d_r & ~sclk_s;
  assign sclk_rise = ~sclk_d_r & sclk_s;
  assign fs_rise = ~fs_n_d_r & fs_n_s;
  assign fs_fall = fs_n_d_r & ~fs_n_s;
  assign rst_rise = ~rst_d_r & rst_s;

  //------------------------------------------------------------
  // frame shift register and bit counter
  //------------------------------------------------------------
  logic [FRAME_BITS-1:0] shift_r, shift_nxt;
  logic [3:0] bitcnt_r, bitcnt_nxt;
  logic whole_r, whole_nxt;
  logic [FRAME_BITS-1:0] frame_word;
  logic [FRAME_BITS-1:0] load_word;
  logic load_shift;

  always_comb begin
    shift_nxt = shift_r;
    bitcnt_nxt = bitcnt_r;
    whole_nxt = whole_r;
    if (fs_fall) begin
      bitcnt_nxt = BITCNT_RESET;
      whole_nxt = 1'b0;
    end else if (!fs_n_s && sclk_fall) begin
      shift_nxt = {shift_r[FRAME_BITS-2:0], din_s};
      bitcnt_nxt = bitcnt_r + 4'h1;
      // set by every sixteenth bit, cleared by any bit after it
      whole_nxt = (bitcnt_r == 4'hf);
    end
    // readback word replaces the frame once it is decoded
    if (load_shift) begin
      shift_nxt = load_word;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      shift_r <= SHIFT_RESET;
      bitcnt_r <= BITCNT_RESET;
      whole_r <= 1'b0;
    end else begin
      shift_r <= shift_nxt;
      bitcnt_r <= bitcnt_nxt;
      whole_r <= whole_nxt;
    end
  end

  //------------------------------------------------------------
  // serial output bit
  //------------------------------------------------------------
  logic sdo_r, sdo_nxt;

  always_comb begin
    sdo_nxt = sdo_r;
    // msb of the register before this clock's shift
    if (!fs_n_s && sclk_rise) begin
      sdo_nxt = shift_r[FRAME_BITS-1];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      sdo_r <= 1'b1;
    end else begin
      sdo_r <= sdo_nxt;
    end
  end

  //------------------------------------------------------------
  // command decode and wiper register
  //------------------------------------------------------------
  logic [DATA_BITS-1:0] wiper_r, wiper_nxt;
  logic [3:0] ctrl_r, ctrl_nxt;
  logic [3:0] busy_r, busy_nxt;
  logic [3:0] cmd;
  logic commit;

  assign frame_word = shift_r;
  assign cmd = frame_word[CMD_MSB:CMD_LSB];
  // commit only on a whole multiple of sixteen bits
  assign commit = fs_rise && whole_r && (bitcnt_r == BITCNT_RESET);

  always_comb begin
    wiper_nxt = wiper_r;
    ctrl_nxt = ctrl_r;
    busy_nxt = (busy_r != BUSY_RESET) ? busy_r - 4'h1 : busy_r;
    load_shift = 1'b0;
    load_word = SHIFT_RESET;
    if (commit) begin
      case (cmd)
        CMD_WRITE: begin
          if (ctrl_r[CTRL_WP_BIT]) begin
            wiper_nxt = frame_word[DATA_BITS-1:0];
          end
          busy_nxt = BUSY_LOAD;
        end
        CMD_READ: begin
          load_shift = 1'b1;
          load_word = {6'h00, wiper_r};
          busy_nxt = BUSY_LOAD;
        end
        CMD_SW_RESET: begin
          wiper_nxt = WIPER_MIDSCALE;
          ctrl_nxt = CTRL_RESET;
          busy_nxt = BUSY_LOAD;
        end
        CMD_CTRL_WRITE: begin
          ctrl_nxt = frame_word[3:0];
        end
        CMD_CTRL_READ: begin
          load_shift = 1'b1;
          load_word = {12'h000, ctrl_r};
        end
        default: begin
        end
      endcase
    end
    if (rst_rise) begin
      wiper_nxt = WIPER_MIDSCALE;
      ctrl_nxt = CTRL_RESET;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wiper_r <= WIPER_MIDSCALE;
      ctrl_r <= CTRL_RESET;
      busy_r <= BUSY_RESET;
    end else begin
      wiper_r <= wiper_nxt;
      ctrl_r <= ctrl_nxt;
      busy_r <= busy_nxt;
    end
  end

  //------------------------------------------------------------
  // registered pin drivers
  //------------------------------------------------------------
  logic so_oe_r, so_oe_nxt;
  logic rdy_oe_r, rdy_oe_nxt;
  logic [DATA_BITS-1:0] wiper_q_r;
  logic [3:0] ctrl_q_r;

  always_comb begin
    so_oe_nxt = ~sdo_nxt;
    rdy_oe_nxt = (busy_nxt != BUSY_RESET);
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      so_oe_r <= 1'b0;
      rdy_oe_r <= 1'b0;
      wiper_q_r <= WIPER_MIDSCALE;
      ctrl_q_r <= CTRL_RESET;
    end else begin
      so_oe_r <= so_oe_nxt;
      rdy_oe_r <= rdy_oe_nxt;
      wiper_q_r <= wiper_nxt;
      ctrl_q_r <= ctrl_nxt;
    end
  end

  // open-drain: output level always low, enable pulls the line
  assign serial_out_o = 1'b0;
  assign serial_out_oe = so_oe_r;
  assign ready_o = 1'b0;
  assign ready_oe = rdy_oe_r;
  assign wiper_register = wiper_q_r;
  assign ctrl_bits = ctrl_q_r;
endmodule

//--- verification/digipot_serial_write_port_asserts.sv
// checker on the serial port pins
// assumes bind to the top module
`timescale 1ns/10ps
module digipot_asserts
  import digipot_pkg::*;
(
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic frame_sel_n,
  input wire logic sclk,
  input wire logic sdin,
  input wire logic hw_reset,
  input wire logic serial_out_o,
  input wire logic serial_out_oe,
  input wire logic ready_o,
  input wire logic ready_oe,
  input wire logic [DATA_BITS-1:0] wiper_register,
  input wire logic [3:0] ctrl_bits
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  a_reset_vals: assert property ($fell(srst) |-> wiper_register == WIPER_MIDSCALE && ctrl_bits == CTRL_RESET)
    else $error("reset values wrong");
  a_open_drain: assert property (serial_out_o == 1'b0 && ready_o == 1'b0)
    else $error("open drain level wrong");
  a_busy_len: assert property ($rose(ready_oe) |-> ready_oe [*5] ##1 !ready_oe)
    else $error("busy length wrong");
  a_busy_cause: assert property ($rose(ready_oe) |-> frame_sel_n && $past(frame_sel_n, 3))
    else $error("busy without frame end");
  a_commit_idle: assert property ($changed(wiper_register) |-> frame_sel_n)
    else $error("wiper changed in frame");
  a_frame_stable: assert property ((!frame_sel_n) [*6] |=> $stable(wiper_register))
    else $error("wiper moved while selected");
  a_write_guard: assert property ($changed(wiper_register) && wiper_register != WIPER_MIDSCALE
    |-> ctrl_bits[CTRL_WP_BIT])
    else $error("protected wiper written");
  a_out_frame: assert property ($changed(serial_out_oe) |-> !frame_sel_n)
    else $error("serial out moved idle");
  a_hw_reset: assert property ($rose(hw_reset) |-> ##[1:6] wiper_register == WIPER_MIDSCALE)
    else $error("reset pin ignored");
endmodule
bind digipot_serial_write_port digipot_asserts digipot_asserts_i (.ref_clk(ref_clk), .srst(srst),
  .frame_sel_n(frame_sel_n), .sclk(sclk), .sdin(sdin), .hw_reset(hw_reset), .serial_out_o(serial_out_o),
  .serial_out_oe(serial_out_oe), .ready_o(ready_o), .ready_oe(ready_oe), .wiper_register(wiper_register),
  .ctrl_bits(ctrl_bits));

//--- verification/spi_host_model.sv
// host model driving the frame pins
// assumes drive at falling ref_clk, pull-up on serial out
`timescale 1ns/10ps
module spi_host_model (
  input wire logic ref_clk,
  input wire logic serial_out_oe,
  input wire logic ready_oe,
  output logic frame_sel_n,
  output logic sclk,
  output logic sdin
);
  logic [15:0] rx;
  int busy_seen;
  initial begin
    busy_seen = 0;
    frame_sel_n = 1'b1;
    sclk = 1'b0;
    sdin = 1'b0;
    rx = 16'h0000;
  end
  // one frame msb first, clock idles low
  task automatic send(input logic [31:0] w, input int n);
    @(negedge ref_clk) frame_sel_n = 1'b0;
    repeat (4) @(negedge ref_clk);
    for (int i = n - 1; i >= 0; i--) begin
      sdin = w[i];
      sclk = 1'b1;
      repeat (4) @(negedge ref_clk);
      sclk = 1'b0;
      repeat (4) @(negedge ref_clk);
      rx = {rx[14:0], !serial_out_oe};
    end
    sdin = !sdin;
    frame_sel_n = 1'b1;
    busy_seen = 0;
    // cycles the completion line is held low after the frame
    repeat (16) begin
      @(negedge ref_clk);
      if (ready_oe === 1'b1) busy_seen++;
    end
  endtask
endmodule

//--- verification/tb_digipot_serial_write_port.sv
// bench for the serial port
// assumes host model and bound checker
`timescale 1ns/10ps
`define CHK(nm, e, a) begin checks++; if ((a) !== (e)) begin fails++; $display("CHECK FAILED %s %h %h", nm, e, a); end end
module tb_digipot_serial_write_port
  import digipot_pkg::*;
;
  logic ref_clk, srst, hw_reset, frame_sel_n, sclk, sdin;
  logic serial_out_o, serial_out_oe, ready_o, ready_oe;
  logic [DATA_BITS-1:0] wiper_register;
  logic [3:0] ctrl_bits;
  int fails = 0;
  int checks = 0;
  int cycles = 0;
  digipot_serial_write_port digipot_serial_write_port_i (.ref_clk(ref_clk), .srst(srst),
    .frame_sel_n(frame_sel_n), .sclk(sclk), .sdin(sdin), .hw_reset(hw_reset), .serial_out_o(serial_out_o),
    .serial_out_oe(serial_out_oe), .ready_o(ready_o), .ready_oe(ready_oe), .wiper_register(wiper_register),
    .ctrl_bits(ctrl_bits));
  spi_host_model spi_host_model_i (.ref_clk(ref_clk), .serial_out_oe(serial_out_oe), .ready_oe(ready_oe),
    .frame_sel_n(frame_sel_n), .sclk(sclk), .sdin(sdin));
  task automatic summarize();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic t_write();
    spi_host_model_i.send(32'h0555, 16);
    `CHK("protected", WIPER_MIDSCALE, wiper_register)
    `CHK("busy", BUSY_CYCLES, spi_host_model_i.busy_seen)
    spi_host_model_i.send(32'h1002, 16);
    `CHK("ctrl", 4'h2, ctrl_bits)
    `CHK("no busy", 0, spi_host_model_i.busy_seen)
    spi_host_model_i.send(32'h0555, 16);
    `CHK("wiper", 10'h155, wiper_register)
    $display("t_write done");
  endtask
  task automatic t_length();
    spi_host_model_i.send(32'h04aa, 8);
    `CHK("abort", 10'h155, wiper_register)
    spi_host_model_i.send(32'h04aa, 17);
    `CHK("odd", 10'h155, wiper_register)
    spi_host_model_i.send(32'h04f0, 32);
    `CHK("long", 10'h0f0, wiper_register)
    $display("t_length done");
  endtask
  task automatic t_read();
    spi_host_model_i.send(32'h0800, 16);
    spi_host_model_i.send(32'h0000, 16);
    `CHK("readback", 16'h00f0, spi_host_model_i.rx)
    spi_host_model_i.send(32'h1400, 16);
    `CHK("ctrl read", 10'h0f0, wiper_register)
    spi_host_model_i.send(32'h0c00, 16);
    `CHK("sw reset", WIPER_MIDSCALE, wiper_register)
    `CHK("sw reset ctrl", CTRL_RESET, ctrl_bits)
    `CHK("ctrl readback", 16'h0002, spi_host_model_i.rx)
    $display("t_read done");
  endtask
  task automatic t_hw();
    spi_host_model_i.send(32'h1002, 16);
    spi_host_model_i.send(32'h0555, 16);
    `CHK("pre reset", 10'h155, wiper_register)
    hw_reset = 1'b1;
    repeat (10) @(negedge ref_clk);
    `CHK("pin reset", WIPER_MIDSCALE, wiper_register)
    `CHK("pin ctrl", CTRL_RESET, ctrl_bits)
    hw_reset = 1'b0;
    $display("t_hw done");
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      summarize();
    end
  end
  initial begin
    srst = 1'b1;
    hw_reset = 1'b0;
    repeat (12) @(negedge ref_clk);
    srst = 1'b0;
    repeat (4) @(negedge ref_clk);
    `CHK("reset wiper", WIPER_MIDSCALE, wiper_register)
    `CHK("reset ready", 1'b0, ready_oe)
    `CHK("od levels", 2'b00, {serial_out_o, ready_o})
    t_write();
    t_length();
    t_read();
    t_hw();
    summarize();
  end
endmodule
